// ---- bench/bcd_host_model.sv ----
/*
  host framer model: clocks bytes on scl_pin and reports each acknowledge
  assumes the decoder samples scl_pin through synchronisers on clk
*/
`timescale 1ns/1ps
module bcd_host_model (
  input wire logic clk,
  input wire logic ack_reg,
  output logic scl_pin,
  output logic rx_valid,
  output logic rx_first,
  output logic [7:0] rx_byte,
  output logic ack_phase,
  output logic ack_got,
  output logic done
);
  // idle bus: scl stands high between frames
  initial begin
    scl_pin = 1'b1;
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_byte = 8'h00;
    ack_phase = 1'b0;
    ack_got = 1'b0;
    done = 1'b0;
  end
  // one half of a 200 ns link clock period
  task automatic half(input logic lvl);
    scl_pin = lvl;
    repeat (4) @(negedge clk);
  endtask
  // one byte of a command string, then its acknowledge bit
  task automatic xfer(input logic [7:0] b, input logic first);
    for (int i = 0; i < 8; i++) begin
      half(1'b0);
      half(1'b1);
    end
    scl_pin = 1'b0;
    rx_valid = 1'b1;
    rx_first = first;
    rx_byte = b;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_byte = ~b;
    // raise the bit only once the synchronised fall that opens it has gone by,
    // otherwise that fall would already count as the end of the bit
    repeat (2) @(negedge clk);
    ack_phase = 1'b1;
    @(negedge clk);
    scl_pin = 1'b1;
    @(negedge clk);
    ack_got = ack_reg;
    repeat (3) @(negedge clk);
    scl_pin = 1'b0;
    // hold the bit long enough for reset and commit to land
    repeat (8) @(negedge clk);
    ack_phase = 1'b0;
    scl_pin = 1'b1;
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
  endtask
endmodule // bcd_host_model

// ---- bench/tb_bridge_command_decoder.sv ----
/*
  self-checking bench of the command decoder with a host model and engine stand-in
  assumes core/bcd_pkg.sv, core/bcd_decoder.sv and the include path of core/
*/
`timescale 1ns/1ps
`include "bcd_map.svh"
module tb_bridge_command_decoder;
  import bcd_pkg::*;
  typedef struct packed {logic ack; logic [7:0] rd;} bcd_note_s;
  localparam logic [7:0] c_ptr = `BCD_CMD_SET_PTR;
  localparam logic [7:0] c_cfg = `BCD_CMD_WR_CFG;
  localparam logic [7:0] c_lrst = `BCD_CMD_LINE_RST;
  localparam logic [7:0] c_wrb = `BCD_CMD_WR_BYTE;
  logic clk, rstn, line_pin, eng_done, ack_reg, busy_reg, abort_reg, start_reg;
  logic scl_pin, rx_valid, rx_first, ack_phase, ack_got, done, scl_prev, rst_flag, busy;
  logic [7:0] rx_byte, rd_byte_reg, ptr, data, b;
  logic [7:0] codes [3];
  logic [4:0] flags;
  logic [3:0] cfg, n;
  logic [31:0] seed;
  bcd_res_s eng_res;
  bcd_cfg_s cfg_reg;
  bcd_launch_s launch_reg;
  bcd_note_s notes[$];
  bcd_note_s nt;
  int errors, checks, eng_cnt, eng_wait, lat, cnt;

  bcd_decoder i_dut (.clk(clk), .rstn(rstn), .ce(1'b1), .scl_pin(scl_pin),
    .line_pin(line_pin), .rx_valid(rx_valid), .rx_first(rx_first), .rx_byte(rx_byte),
    .ack_phase(ack_phase), .eng_done(eng_done), .eng_res(eng_res), .ack_reg(ack_reg),
    .rd_byte_reg(rd_byte_reg), .cfg_reg(cfg_reg), .busy_reg(busy_reg),
    .abort_reg(abort_reg), .start_reg(start_reg), .launch_reg(launch_reg));
  bcd_host_model i_host (.clk(clk), .ack_reg(ack_reg), .scl_pin(scl_pin),
    .rx_valid(rx_valid), .rx_first(rx_first), .rx_byte(rx_byte), .ack_phase(ack_phase),
    .ack_got(ack_got), .done(done));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // byte the host should read next, from the bench's own register picture
  function automatic logic [7:0] exp_rd();
    case (ptr)
      `BCD_PTR_RDATA: return data;
      `BCD_PTR_CFG: return {4'h0, cfg};
      default: return {flags[4:2], rst_flag, line_pin, flags[1:0], busy};
    endcase
  endfunction
  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  // note the expectation, then send; line level is stirred each byte
  task automatic op(input logic [7:0] bv, input logic first, input logic ack);
    seed = nxt(seed);
    line_pin = seed[0];
    notes.push_back({ack, exp_rd()});
    i_host.xfer(bv, first);
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // oldest note against the acknowledge and the byte on offer
  always @(posedge clk) begin
    if (done) begin
      nt = notes.pop_front();
      cmp1(ack_got, nt.ack);
      cmp8(rd_byte_reg, nt.rd);
    end
  end
  // engine stand-in: done after eng_wait cycles unless aborted first
  always @(negedge clk) begin
    eng_done = (eng_cnt == 1);
    if (abort_reg) eng_cnt = 0;
    else if (start_reg) eng_cnt = eng_wait;
    else if (eng_cnt != 0) eng_cnt--;
  end
  // cycles from the last scl fall to an abort pulse
  always @(posedge clk) begin
    if (abort_reg) lat = cnt;
    cnt = (scl_prev && !scl_pin) ? 0 : cnt + 1;
    scl_prev = scl_pin;
  end
  // a hang ends the run as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    wrap_up;
  end
  initial begin
    rstn = 1'b0;
    line_pin = 1'b1;
    eng_done = 1'b0;
    eng_res = '0;
    {errors, checks, eng_cnt, cnt} = '0;
    eng_wait = 400;
    lat = 99;
    scl_prev = 1'b1;
    seed = 32'd77618;
    codes = '{`BCD_PTR_STATUS, `BCD_PTR_RDATA, `BCD_PTR_CFG};
    ptr = `BCD_PTR_STATUS;
    data = `BCD_RDATA_RST;
    {flags, busy, cfg} = '0;
    rst_flag = 1'b1;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    cmp8({5'h00, cfg_reg}, 8'h00);
    op(8'h00, 1'b1, 1'b0);
    op(8'hff, 1'b1, 1'b0);
    foreach (codes[i]) begin
      op(c_ptr, 1'b1, 1'b1);
      ptr = codes[i];
      op(codes[i], 1'b0, 1'b1);
    end
    seed = nxt(seed);
    b = (seed[7:0] inside {8'hf0, 8'he1, 8'hc3}) ? seed[7:0] ^ 8'h01 : seed[7:0];
    op(c_ptr, 1'b1, 1'b1);
    op(b, 1'b0, 1'b0);
    repeat (4) begin
      seed = nxt(seed);
      n = seed[3:0];
      op(c_cfg, 1'b1, 1'b1);
      {cfg, rst_flag, ptr} = {n & 4'hd, 1'b0, `BCD_PTR_CFG};
      op({~n, n}, 1'b0, 1'b1);
      cmp8({5'h00, cfg_reg}, {5'h00, n[3], n[2], n[0]});
    end
    op(c_ptr, 1'b1, 1'b1);
    ptr = `BCD_PTR_STATUS;
    op(`BCD_PTR_STATUS, 1'b0, 1'b1);
    op(c_cfg, 1'b1, 1'b1);
    op({~n ^ 4'h8, n}, 1'b0, 1'b0);
    // line transfer keeps the decoder busy
    seed = nxt(seed);
    eng_res = seed[12:0];
    busy = 1'b1;
    op(c_lrst, 1'b1, 1'b1);
    cmp8(launch_reg.cmd, c_lrst);
    op(c_cfg, 1'b1, 1'b0);
    op(8'h0f, 1'b0, 1'b0);
    for (int k = 0; k < 1000 && busy_reg !== 1'b0; k++) @(negedge clk);
    busy = 1'b0;
    flags = {eng_res.dir, eng_res.bit2, eng_res.bit1, eng_res.shorted, eng_res.presence};
    data = eng_res.data;
    op(c_ptr, 1'b1, 1'b1);
    ptr = `BCD_PTR_RDATA;
    op(`BCD_PTR_RDATA, 1'b0, 1'b1);
    op(c_ptr, 1'b1, 1'b1);
    ptr = `BCD_PTR_STATUS;
    op(`BCD_PTR_STATUS, 1'b0, 1'b1);
    op(c_cfg, 1'b1, 1'b1);
    {cfg, ptr} = {4'hd, `BCD_PTR_CFG};
    op(8'h2d, 1'b0, 1'b1);
    // device reset in the middle of a two-byte line transfer
    op(c_wrb, 1'b1, 1'b1);
    seed = nxt(seed);
    b = seed[15:8];
    {busy, ptr} = {1'b1, `BCD_PTR_STATUS};
    op(b, 1'b0, 1'b1);
    cmp8(launch_reg.cmd, c_wrb);
    cmp8(launch_reg.param, b);
    {busy, flags, cfg, rst_flag} = {10'h000, 1'b1};
    op(`BCD_CMD_DEV_RESET, 1'b1, 1'b1);
    cmp1(lat <= 10, 1'b1);
    cmp8({5'h00, cfg_reg}, 8'h00);
    wrap_up;
  end
endmodule // tb_bridge_command_decoder

// ---- core/bcd_decoder.sv ----
/*
  command decoder of a two-wire to single-wire bridge: decodes command
  strings, decides acknowledge, keeps pointer, status and configuration.
  assumes a framer on clk that pulses rx_valid per written byte before its
  acknowledge bit, samples ack_reg during that bit, and holds ack_phase high
  across it; a line engine on clk runs transfers and pulses eng_done.
*/
`timescale 1ns/1ps
`include "bcd_map.svh"

// Contract
// - commands arrive as one or two bytes; eight command codes are decoded.
// - acknowledge accepted bytes, withhold acknowledge for bad codes or parameters.
// - pointer codes select status, read data or configuration for reading.
// - device reset code resets all logic and aborts any line transfer; read data keeps its value here.
// - device reset is always accepted, even while busy.
// - device reset completes within 525 ns of acknowledge falling clock edge.
// - line activity stops within 262.5 ns of acknowledge falling clock edge.
// - after device reset the pointer selects the status register.
// - device reset sets reset flag, clears busy and all result flags.
// - device reset clears speed, active pullup and strong pullup bits.
// - set-pointer is code plus pointer byte; pointer moves there.
// - set-pointer overrides transfer pointer, touches nothing else.
// - invalid pointer byte is not acknowledged and command is ignored.
// - pointer updates on rising clock edge of pointer byte acknowledge.
// - configuration write is code plus byte; takes effect at once.
// - configuration byte accepted only if upper nibble inverts lower nibble.
// - configuration reads back zero upper nibble, stored lower nibble.
// - configuration code while busy: code and byte not acknowledged, ignored.
// - configuration stored on rising edge of its acknowledge; no line activity.
// - after configuration write the pointer selects configuration.
// - accepted configuration write clears the reset flag.
// - busy flag is one during a transfer, zero after completion.
module bcd_decoder (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic line_pin,
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic [7:0] rx_byte,
  input wire logic ack_phase,
  input wire logic eng_done,
  input wire bcd_pkg::bcd_res_s eng_res,
  output logic ack_reg,
  output logic [7:0] rd_byte_reg,
  output bcd_pkg::bcd_cfg_s cfg_reg,
  output logic busy_reg,
  output logic abort_reg,
  output logic start_reg,
  output bcd_pkg::bcd_launch_s launch_reg
);
  import bcd_pkg::*;

  localparam int STOP_CYC = `BCD_STOP_CYC;
  localparam int RST_CYC = `BCD_RST_CYC;

  logic scl_s1, scl_s2, scl_s3, line_s1, line_s2;
  logic scl_rise, scl_fall;
  bcd_state_e st_reg, st_next;
  bcd_act_e act_reg, act_next;
  logic [7:0] cmd_reg, cmd_next, pend_reg, pend_next, ptr_reg, ptr_next;
  logic [7:0] rdata_reg, rdata_next, rd_byte_next;
  logic [3:0] cfgn_reg, cfgn_next;
  logic ack_next, busy_next, abort_next, start_next, rstf_reg, rstf_next;
  logic ppd_reg, ppd_next, sd_reg, sd_next, sbr_reg, sbr_next;
  logic tsb_reg, tsb_next, dir_reg, dir_next;
  bcd_launch_s launch_next;

  function automatic logic ptr_ok(input logic [7:0] c);
    return c == `BCD_PTR_STATUS || c == `BCD_PTR_RDATA || c == `BCD_PTR_CFG;
  endfunction

  function automatic logic cfg_ok(input logic [7:0] b);
    return b[7:4] == ~b[3:0];
  endfunction

  // clock and line pins are foreign: two flops, edges from the second on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      line_s1 <= 1'b1;
      line_s2 <= 1'b1;
    end else if (ce) begin
      scl_s1 <= scl_pin;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      line_s1 <= line_pin;
      line_s2 <= line_s1;
    end
  end

  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;

  // next state of the whole decoder; later blocks win over earlier ones
  always_comb begin
    st_next = st_reg;
    act_next = act_reg;
    cmd_next = cmd_reg;
    pend_next = pend_reg;
    ptr_next = ptr_reg;
    cfgn_next = cfgn_reg;
    ack_next = ack_reg;
    busy_next = busy_reg;
    rstf_next = rstf_reg;
    ppd_next = ppd_reg;
    sd_next = sd_reg;
    sbr_next = sbr_reg;
    tsb_next = tsb_reg;
    dir_next = dir_reg;
    rdata_next = rdata_reg;
    launch_next = launch_reg;
    abort_next = 1'b0;
    start_next = 1'b0;
    // engine completion first, so a launch in the same cycle keeps busy
    // busy ends
    if (eng_done) begin
      busy_next = 1'b0;
      ppd_next = eng_res.presence;
      sd_next = eng_res.shorted;
      sbr_next = eng_res.bit1;
      tsb_next = eng_res.bit2;
      dir_next = eng_res.dir;
      rdata_next = eng_res.data;
    end
    if (rx_valid) begin
      ack_next = 1'b0;
      act_next = ACT_NONE;
      st_next = ST_DROP;
      if (rx_first) begin
        cmd_next = rx_byte;
        unique case (rx_byte)
          `BCD_CMD_DEV_RESET: begin
            ack_next = 1'b1;
            act_next = ACT_RESET;
          end
          `BCD_CMD_SET_PTR: begin
            ack_next = 1'b1;
            st_next = ST_PARAM;
          end
          `BCD_CMD_WR_CFG, `BCD_CMD_ONE_BIT, `BCD_CMD_WR_BYTE, `BCD_CMD_TRIPLET: begin
            ack_next = ~busy_reg;
            st_next = busy_reg ? ST_DROP : ST_PARAM;
          end
          `BCD_CMD_LINE_RST, `BCD_CMD_RD_BYTE: begin
            ack_next = ~busy_reg;
            act_next = busy_reg ? ACT_NONE : ACT_LAUNCH;
          end
          default: ack_next = 1'b0;
        endcase
      end else if (st_reg == ST_PARAM) begin
        pend_next = rx_byte;
        ack_next = 1'b1;
        if (cmd_reg == `BCD_CMD_SET_PTR) begin
          ack_next = ptr_ok(rx_byte);
          act_next = ptr_ok(rx_byte) ? ACT_PTR : ACT_NONE;
        end else if (cmd_reg == `BCD_CMD_WR_CFG) begin
          ack_next = cfg_ok(rx_byte);
          act_next = cfg_ok(rx_byte) ? ACT_CFG : ACT_NONE;
        end else begin
          act_next = ACT_LAUNCH;
        end
      end
    end
    if (ack_phase && scl_rise) begin
      if (act_reg == ACT_PTR) begin
        ptr_next = pend_reg;
        act_next = ACT_NONE;
      end else if (act_reg == ACT_CFG) begin
        cfgn_next = {pend_reg[3:2], 1'b0, pend_reg[0]};
        rstf_next = 1'b0;
        ptr_next = `BCD_PTR_CFG;
        act_next = ACT_NONE;
      end
    end
    // line transfers start when the acknowledge bit ends
    if (ack_phase && scl_fall && act_reg == ACT_LAUNCH) begin
      busy_next = 1'b1;
      start_next = 1'b1;
      launch_next = '{cmd: cmd_reg, param: pend_reg};
      ptr_next = `BCD_PTR_STATUS;
      act_next = ACT_NONE;
    end
    // global reset on ack falling edge
    if (ack_phase && scl_fall && act_reg == ACT_RESET) begin
      abort_next = 1'b1;
      ptr_next = `BCD_PTR_STATUS;
      rstf_next = 1'b1;
      busy_next = 1'b0;
      ppd_next = 1'b0;
      sd_next = 1'b0;
      sbr_next = 1'b0;
      tsb_next = 1'b0;
      dir_next = 1'b0;
      cfgn_next = `BCD_CFG_RST;
      act_next = ACT_NONE;
      st_next = ST_IDLE;
    end
    // read byte follows the pointer; upper config nibble always zero
    // register select
    unique case (ptr_reg)
      `BCD_PTR_RDATA: rd_byte_next = rdata_reg;
      `BCD_PTR_CFG: rd_byte_next = {4'h0, cfgn_reg};
      default: rd_byte_next = {dir_reg, tsb_reg, sbr_reg, rstf_reg,
                               line_s2, sd_reg, ppd_reg, busy_reg};
    endcase
  end

  // register stage; power-on pointer, status and configuration equal the device reset result; read data powers on to zero
  // power-on state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ST_IDLE;
      act_reg <= ACT_NONE;
      cmd_reg <= 8'h00;
      pend_reg <= 8'h00;
      ptr_reg <= `BCD_PTR_STATUS;
      cfgn_reg <= `BCD_CFG_RST;
      ack_reg <= 1'b0;
      busy_reg <= 1'b0;
      rstf_reg <= 1'b1;
      ppd_reg <= 1'b0;
      sd_reg <= 1'b0;
      sbr_reg <= 1'b0;
      tsb_reg <= 1'b0;
      dir_reg <= 1'b0;
      rdata_reg <= `BCD_RDATA_RST;
      rd_byte_reg <= 8'h00;
      launch_reg <= '0;
      abort_reg <= 1'b0;
      start_reg <= 1'b0;
      cfg_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
      act_reg <= act_next;
      cmd_reg <= cmd_next;
      pend_reg <= pend_next;
      ptr_reg <= ptr_next;
      cfgn_reg <= cfgn_next;
      ack_reg <= ack_next;
      busy_reg <= busy_next;
      rstf_reg <= rstf_next;
      ppd_reg <= ppd_next;
      sd_reg <= sd_next;
      sbr_reg <= sbr_next;
      tsb_reg <= tsb_next;
      dir_reg <= dir_next;
      rdata_reg <= rdata_next;
      rd_byte_reg <= rd_byte_next;
      launch_reg <= launch_next;
      abort_reg <= abort_next;
      start_reg <= start_next;
      cfg_reg <= '{speed: cfgn_next[`BCD_CFG_SPEED], strong_pullup_enable: cfgn_next[`BCD_CFG_SPU],
                   active_pullup_enable: cfgn_next[`BCD_CFG_APU]};
    end
  end

  // checks; they assume ce stays high while they watch
  sequence reset_ack_fall;
    ack_phase && ~scl_s2 && scl_s3 && act_reg == ACT_RESET;
  endsequence

  sequence cfg_ack_rise;
    ack_phase && scl_s2 && ~scl_s3 && act_reg == ACT_CFG;
  endsequence

  chk_stop_time: assert property (@(posedge clk) disable iff (!rstn)
    reset_ack_fall |-> ##[1:STOP_CYC] abort_reg)
    else $error("abort late after reset acknowledge");

  chk_reset_done: assert property (@(posedge clk) disable iff (!rstn)
    reset_ack_fall |-> ##[1:RST_CYC] (rstf_reg && cfg_reg == '0))
    else $error("device reset not complete in time");

  chk_reset_flags: assert property (@(posedge clk) disable iff (!rstn)
    abort_reg |-> rstf_reg && !busy_reg && !ppd_reg && !sd_reg && !sbr_reg && !tsb_reg && !dir_reg)
    else $error("status flags wrong after reset");

  chk_reset_ptr: assert property (@(posedge clk) disable iff (!rstn)
    abort_reg |-> ptr_reg == `BCD_PTR_STATUS && cfgn_reg == `BCD_CFG_RST)
    else $error("pointer or config wrong after reset");

  chk_reset_acked: assert property (@(posedge clk) disable iff (!rstn)
    ce && rx_valid && rx_first && rx_byte == `BCD_CMD_DEV_RESET |=> ack_reg)
    else $error("device reset refused");

  chk_unknown_nack: assert property (@(posedge clk) disable iff (!rstn)
    ce && rx_valid && rx_first && !(rx_byte inside {`BCD_CMD_DEV_RESET, `BCD_CMD_SET_PTR,
      `BCD_CMD_WR_CFG, `BCD_CMD_LINE_RST, `BCD_CMD_ONE_BIT, `BCD_CMD_WR_BYTE,
      `BCD_CMD_RD_BYTE, `BCD_CMD_TRIPLET}) |=> !ack_reg && act_reg == ACT_NONE)
    else $error("unknown code acknowledged");

  chk_bad_ptr: assert property (@(posedge clk) disable iff (!rstn)
    ce && rx_valid && !rx_first && st_reg == ST_PARAM && cmd_reg == `BCD_CMD_SET_PTR
      && !ptr_ok(rx_byte) |=> !ack_reg && act_reg == ACT_NONE)
    else $error("invalid pointer acknowledged");

  chk_cfg_busy: assert property (@(posedge clk) disable iff (!rstn)
    ce && rx_valid && rx_first && rx_byte == `BCD_CMD_WR_CFG && busy_reg |=> !ack_reg
      && st_reg == ST_DROP)
    else $error("config accepted while busy");

  chk_cfg_store: assert property (@(posedge clk) disable iff (!rstn)
    cfg_ack_rise |=> cfgn_reg == {$past(pend_reg[3:2]), 1'b0, $past(pend_reg[0])}
      && !rstf_reg && ptr_reg == `BCD_PTR_CFG && !start_reg ##1 rd_byte_reg[7:4] == 4'h0)
    else $error("config write not stored or read back");

  chk_busy_start: assert property (@(posedge clk) disable iff (!rstn)
    start_reg |-> busy_reg && ptr_reg == `BCD_PTR_STATUS)
    else $error("transfer started without busy");
endmodule // bcd_decoder

// ---- core/bcd_map.svh ----
/*
  offsets, codes, field positions, reset values and timing counts
  of the bridge command decoder; included by the decoder and the bench
*/
`ifndef BCD_MAP_SVH
`define BCD_MAP_SVH
// function command codes
`define BCD_CMD_DEV_RESET 8'hf0
`define BCD_CMD_SET_PTR 8'he1
`define BCD_CMD_WR_CFG 8'hd2
`define BCD_CMD_LINE_RST 8'hb4
`define BCD_CMD_ONE_BIT 8'h87
`define BCD_CMD_WR_BYTE 8'ha5
`define BCD_CMD_RD_BYTE 8'h96
`define BCD_CMD_TRIPLET 8'h78
// pointer codes, equal to the register offsets
`define BCD_PTR_STATUS 8'hf0
`define BCD_PTR_RDATA 8'he1
`define BCD_PTR_CFG 8'hc3
// configuration nibble positions
`define BCD_CFG_APU 0
`define BCD_CFG_SPU 2
`define BCD_CFG_SPEED 3
// reset values
`define BCD_CFG_RST 4'h0
`define BCD_RDATA_RST 8'h00
// timing in picoseconds; longest times round down to cycles
`define BCD_CLK_PS 25000
`define BCD_RST_MAX_PS 525000
`define BCD_STOP_MAX_PS 262500
`define BCD_RST_CYC (`BCD_RST_MAX_PS / `BCD_CLK_PS)
`define BCD_STOP_CYC (`BCD_STOP_MAX_PS / `BCD_CLK_PS)
`endif

// ---- core/bcd_pkg.sv ----
/*
  types of the bridge command decoder: states, pending actions, carriers
  assumes nothing beyond a SystemVerilog compiler
*/
package bcd_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_PARAM, ST_DROP} bcd_state_e;
  typedef enum logic [2:0] {ACT_NONE, ACT_RESET, ACT_PTR, ACT_CFG, ACT_LAUNCH} bcd_act_e;
  // results handed back by the line engine when a transfer completes
  typedef struct packed {
    logic presence;
    logic shorted;
    logic bit1;
    logic bit2;
    logic dir;
    logic [7:0] data;
  } bcd_res_s;
  // live feature settings
  typedef struct packed {
    logic speed;
    logic strong_pullup_enable;
    logic active_pullup_enable;
  } bcd_cfg_s;
  // line transfer request
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] param;
  } bcd_launch_s;
endpackage
